// ===== src/frt_timer.sv
// What this block does
// [RULE_01] One 32-bit up counter, ticks when enabled
// [RULE_02] Keeps counting in stop mode if clock runs
// [RULE_03] Sub oscillator feeds the counter directly
// [RULE_04] Mode bits 5:4 pick counting clock source
// [RULE_05] Match with clear on: zero, wait flag
// [RULE_06] Match with clear off: keep counting
// [RULE_07] Mode bit 1 enables overflow interrupt
// [RULE_08] Mode bit 0 enables match interrupt
// [RULE_09] Read request auto-clears on acknowledge
// [RULE_10] Acknowledge bit shows captured value ready
// [RULE_11] Clear bit write one zeroes counter
// [RULE_12] Hold bit freezes the counter
// [RULE_13] Full 32-bit read/write period register
// [RULE_14] Counter register is read only
// [RULE_15] Overflow flag set on wrap, write-one clear
// [RULE_16] Match flag set on match, write-one clear
// [RULE_17] Control bit 0 enables counting
// [RULE_18] Interrupt from enabled flags
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module frt_timer (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire frt_pkg::frt_bus_s bus,
  output logic [31:0]            rdata,
  input  wire logic              lsi_clk_pin,
  input  wire logic              ext_osc_pin,
  input  wire logic              sub_oscillator_pin,
  output logic                   irq
);

  // Whole state of the block
  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  control;
    logic [31:0] period;
    logic [31:0] count;
    logic [31:0] snapshot;
    logic        match_flag;
    logic        ovf_flag;
    logic        read_acknowledge;
    logic [2:0]  mask;
    logic [4:0]  ext_div;
    logic [2:0]  lsi_sync;
    logic [2:0]  ext_sync;
    logic [2:0]  sub_sync;
    logic        lsi_level;
    logic        ext_level;
    logic        sub_level;
    logic [31:0] rdata;
  } frt_state_s;

  frt_state_s state_reg;  // Registered state
  frt_state_s state_next; // Next state

  // Combinational helpers
  logic        lsi_rise;    // Filtered rising edges
  logic        ext_rise;
  logic        sub_rise;
  logic        ext_tick;    // Divided external tick
  logic        tick;        // Selected count tick
  logic        running;     // Counter may advance
  logic        is_match;    // Counter equals period
  logic        wr_ctrl;     // Decoded strobes
  logic        wr_stat;
  logic [2:0]  stat_vec;    // Status bits
  logic [31:0] rd_value;    // Read mux

  // Edge detection once stages 1 and 2 agree; stage 0 feeds stage 1 only
  always_comb begin
    lsi_rise = (state_reg.lsi_sync[1] == state_reg.lsi_sync[2]) &&
               state_reg.lsi_sync[2] && !state_reg.lsi_level;
    ext_rise = (state_reg.ext_sync[1] == state_reg.ext_sync[2]) &&
               state_reg.ext_sync[2] && !state_reg.ext_level;
    sub_rise = (state_reg.sub_sync[1] == state_reg.sub_sync[2]) &&
               state_reg.sub_sync[2] && !state_reg.sub_level;
  end

  // Tick selection; reserved code never ticks
  always_comb begin
    ext_tick = ext_rise && (state_reg.ext_div == frt_pkg::EXT_DIV_MAX);
    case (state_reg.mode[frt_pkg::MODE_COUNT_CLOCK_SOURCE_LO +: 2])       // RULE_04
      frt_pkg::SRC_LSI:     tick = lsi_rise;                   // RULE_02
      frt_pkg::SRC_EXT_DIV: tick = ext_tick;
      frt_pkg::SRC_SUB:     tick = sub_rise;                   // RULE_03
      default:              tick = 1'b0;
    endcase
  end

  // Counting conditions
  always_comb begin
    is_match = (state_reg.count == state_reg.period);
    // Waiting for flag clear blocks counting in clear mode
    running  = state_reg.control[frt_pkg::CTRL_EN] &&          // RULE_17
               !state_reg.control[frt_pkg::CTRL_HOLD] &&         // RULE_12
               !(state_reg.match_flag && !state_reg.mode[frt_pkg::MODE_MCD]);
    wr_ctrl  = bus.wr && (bus.addr == frt_pkg::CONTROL_OFS);
    wr_stat  = bus.wr && (bus.addr == frt_pkg::STATUS_OFS);
    stat_vec = {state_reg.read_acknowledge, state_reg.ovf_flag, state_reg.match_flag};
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (bus.addr)
      frt_pkg::MODE_OFS:     rd_value = {24'h00_0000, state_reg.mode};
      frt_pkg::CONTROL_OFS:  rd_value = {24'h00_0000, 4'h0, 1'b0,
                                         state_reg.control[2:0]};
      frt_pkg::PERIOD_OFS:   rd_value = state_reg.period;        // RULE_13
      frt_pkg::COUNT_OFS:    rd_value = state_reg.snapshot;
      frt_pkg::STATUS_OFS:   rd_value = {29'h0000_0000, stat_vec};
      frt_pkg::IRQ_MASK_OFS: rd_value = {29'h0000_0000, state_reg.mask};
      default:               rd_value = 32'h0000_0000;
    endcase
  end

  // Next-state logic
  always_comb begin
    state_next = state_reg;

    // Pin synchronisers and level trackers
    state_next.lsi_sync = {state_reg.lsi_sync[1:0], lsi_clk_pin};
    state_next.ext_sync = {state_reg.ext_sync[1:0], ext_osc_pin};
    state_next.sub_sync = {state_reg.sub_sync[1:0], sub_oscillator_pin};
    if (state_reg.lsi_sync[1] == state_reg.lsi_sync[2]) begin
      state_next.lsi_level = state_reg.lsi_sync[2];
    end
    if (state_reg.ext_sync[1] == state_reg.ext_sync[2]) begin
      state_next.ext_level = state_reg.ext_sync[2];
    end
    if (state_reg.sub_sync[1] == state_reg.sub_sync[2]) begin
      state_next.sub_level = state_reg.sub_sync[2];
    end
    // Prescaler for the external oscillator
    if (ext_rise) begin
      state_next.ext_div = state_reg.ext_div + 5'h01;
    end

    // Counter advance and period match
    if (running && tick) begin
      if (is_match && !state_reg.mode[frt_pkg::MODE_MCD]) begin
        state_next.count = frt_pkg::COUNT_RESET;                // RULE_05
      end else begin
        state_next.count = state_reg.count + 32'h0000_0001;     // RULE_01 RULE_06
      end
    end

    // Software clear overrides counting; the clear bit self-clears
    state_next.control[frt_pkg::CTRL_CLEAR] = 1'b0;
    if (wr_ctrl && bus.wdata[frt_pkg::CTRL_CLEAR]) begin
      state_next.count = frt_pkg::COUNT_RESET;                  // RULE_11
    end

    // Register writes; count has no write path
    if (bus.wr && (bus.addr == frt_pkg::MODE_OFS)) begin
      state_next.mode = {2'b00, bus.wdata[5:4], 1'b0, bus.wdata[2:0]};
    end
    if (wr_ctrl) begin
      state_next.control[frt_pkg::CTRL_EN]   = bus.wdata[frt_pkg::CTRL_EN];
      state_next.control[frt_pkg::CTRL_HOLD] = bus.wdata[frt_pkg::CTRL_HOLD];
      if (bus.wdata[frt_pkg::CTRL_READ_REQUEST]) begin
        state_next.control[frt_pkg::CTRL_READ_REQUEST] = 1'b1;          // RULE_09
      end
    end
    if (bus.wr && (bus.addr == frt_pkg::PERIOD_OFS)) begin
      state_next.period = bus.wdata;                            // RULE_13
    end
    if (bus.wr && (bus.addr == frt_pkg::IRQ_MASK_OFS)) begin
      state_next.mask = bus.wdata[2:0];
    end

    // Read handshake: drop the request once acknowledged
    if (state_reg.read_acknowledge) begin
      state_next.control[frt_pkg::CTRL_READ_REQUEST] = 1'b0;            // RULE_09
    end
    // Software drops the acknowledge by writing one
    if (wr_stat && bus.wdata[frt_pkg::STAT_READ_ACKNOWLEDGE]) begin
      state_next.read_acknowledge = 1'b0;
    end
    // Capture comes last so a same-cycle acknowledge clear cannot lose it
    if (state_reg.control[frt_pkg::CTRL_READ_REQUEST] && !state_reg.read_acknowledge) begin
      state_next.snapshot = state_reg.count;                    // RULE_14
      state_next.read_acknowledge     = 1'b1;                               // RULE_10
    end

    // Flags: write-one clear, then hardware set wins
    if (wr_stat && bus.wdata[frt_pkg::STAT_MATCH]) begin
      state_next.match_flag = 1'b0;
    end
    if (wr_stat && bus.wdata[frt_pkg::STAT_OVF]) begin
      state_next.ovf_flag = 1'b0;
    end
    if (running && tick && is_match) begin
      state_next.match_flag = 1'b1;                             // RULE_16
    end
    if (running && tick && (state_reg.count == 32'hffff_ffff)) begin
      state_next.ovf_flag = 1'b1;                               // RULE_15
    end

    state_next.rdata = bus.rd ? rd_value : 32'h0000_0000;
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg         <= '0;
      state_reg.mode    <= frt_pkg::MODE_RESET;
      state_reg.control <= frt_pkg::CONTROL_RESET;
      state_reg.period  <= frt_pkg::PERIOD_RESET;
      state_reg.count   <= frt_pkg::COUNT_RESET;
      state_reg.mask    <= frt_pkg::MASK_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign rdata = state_reg.rdata;
  // Mode enables and the mask both gate the line
  assign irq   = (state_reg.match_flag && state_reg.mode[frt_pkg::MODE_MATCH_IE] &&
                  state_reg.mask[frt_pkg::STAT_MATCH]) ||                   // RULE_08 RULE_18
                 (state_reg.ovf_flag && state_reg.mode[frt_pkg::MODE_OVF_IE] &&
                  state_reg.mask[frt_pkg::STAT_OVF]);                       // RULE_07 RULE_18

  // Assertions
  // Parked count stays put until the match flag goes
  match_halt_a: assert property (@(posedge clk) disable iff (reset) // RULE_05
    state_reg.match_flag && !state_reg.mode[frt_pkg::MODE_MCD] &&
    !(wr_ctrl && bus.wdata[frt_pkg::CTRL_CLEAR]) |=> $stable(state_reg.count))
    else $error("count moved while waiting for match clear");
  // Software clear zeroes the count next cycle
  clear_zero_a: assert property (@(posedge clk) disable iff (reset) // RULE_11
    wr_ctrl && bus.wdata[frt_pkg::CTRL_CLEAR] |=> state_reg.count == 32'h0000_0000)
    else $error("clear did not zero count");
  // Hold freezes the count
  hold_freeze_a: assert property (@(posedge clk) disable iff (reset) // RULE_12
    state_reg.control[frt_pkg::CTRL_HOLD] && !wr_ctrl |=> $stable(state_reg.count))
    else $error("count moved under hold");
  // Disabled timer keeps its count
  disable_stop_a: assert property (@(posedge clk) disable iff (reset) // RULE_17
    !state_reg.control[frt_pkg::CTRL_EN] && !wr_ctrl |=> $stable(state_reg.count))
    else $error("count moved while disabled");
  // One tick, one step up
  count_step_a: assert property (@(posedge clk) disable iff (reset) // RULE_01
    running && tick && !is_match && !wr_ctrl |=>
    state_reg.count == $past(state_reg.count) + 32'h0000_0001)
    else $error("count did not step by one");
  // Match with clear disabled never zeroes, except by wrapping
  mcd_keep_a: assert property (@(posedge clk) disable iff (reset) // RULE_06
    running && tick && is_match && state_reg.mode[frt_pkg::MODE_MCD] && !wr_ctrl
    |=> state_reg.count != 32'h0000_0000 || $past(state_reg.count) == 32'hffff_ffff)
    else $error("count zeroed with match clear disabled");
  // Overflow flag is sticky until written one
  ovf_sticky_a: assert property (@(posedge clk) disable iff (reset) // RULE_15
    state_reg.ovf_flag && !(wr_stat && bus.wdata[frt_pkg::STAT_OVF]) |=> state_reg.ovf_flag)
    else $error("overflow flag lost");
  // A counted match raises the match flag
  match_set_a: assert property (@(posedge clk) disable iff (reset) // RULE_16
    running && tick && is_match |=> state_reg.match_flag)
    else $error("match flag not set");
  // Request gets its acknowledge, then goes away
  read_request_ack_a: assert property (@(posedge clk) disable iff (reset) // RULE_09 RULE_10
    state_reg.control[frt_pkg::CTRL_READ_REQUEST] && !state_reg.read_acknowledge |=> state_reg.read_acknowledge ##1
    !state_reg.control[frt_pkg::CTRL_READ_REQUEST] || (wr_ctrl && bus.wdata[frt_pkg::CTRL_READ_REQUEST]))
    else $error("read request handshake broken");
  // No overflow enable and no match flag means a quiet line
  irq_ovf_a: assert property (@(posedge clk) disable iff (reset) // RULE_07
    !state_reg.mode[frt_pkg::MODE_OVF_IE] && !state_reg.match_flag |-> !irq)
    else $error("irq without enabled cause");
  // Enabled, unmasked match flag drives the line
  irq_match_a: assert property (@(posedge clk) disable iff (reset) // RULE_08 RULE_18
    state_reg.match_flag && state_reg.mode[frt_pkg::MODE_MATCH_IE] &&
    state_reg.mask[frt_pkg::STAT_MATCH] |-> irq)
    else $error("match irq missing");

  // Read handshake steps: request open, capture with acknowledge, request gone
  sequence rd_req_open_s;
    state_reg.control[frt_pkg::CTRL_READ_REQUEST] && !state_reg.read_acknowledge;
  endsequence
  sequence rd_ack_up_s;
    state_reg.read_acknowledge && (state_reg.snapshot == $past(state_reg.count));
  endsequence
  sequence rd_req_gone_s;
    !state_reg.control[frt_pkg::CTRL_READ_REQUEST];
  endsequence
  // Clear-on-match steps: the matching tick, then a parked zero count
  sequence match_clear_hit_s;
    running && tick && is_match && !state_reg.mode[frt_pkg::MODE_MCD];
  endsequence
  sequence parked_zero_s;
    (state_reg.count == 32'h0000_0000) && state_reg.match_flag;
  endsequence

  // Snapshot is the count of the cycle the request was seen
  read_handshake_a: assert property (@(posedge clk) disable iff (reset) // RULE_09 RULE_10
    rd_req_open_s |=> rd_ack_up_s ##1 rd_req_gone_s)
    else $error("read handshake did not capture and drop");
  // Snapshot cannot move while the acknowledge stands
  snap_keep_a: assert property (@(posedge clk) disable iff (reset) // RULE_14
    state_reg.read_acknowledge |=> $stable(state_reg.snapshot))
    else $error("snapshot moved under acknowledge");
  // Capture wins over a same-cycle acknowledge clear
  read_acknowledge_set_win_a: assert property (@(posedge clk) disable iff (reset) // RULE_10
    state_reg.control[frt_pkg::CTRL_READ_REQUEST] && !state_reg.read_acknowledge &&
    wr_stat && bus.wdata[frt_pkg::STAT_READ_ACKNOWLEDGE] |=> state_reg.read_acknowledge)
    else $error("acknowledge lost to its clear");
  // Writing one drops a standing acknowledge
  read_acknowledge_w1c_a: assert property (@(posedge clk) disable iff (reset) // RULE_10
    state_reg.read_acknowledge && wr_stat && bus.wdata[frt_pkg::STAT_READ_ACKNOWLEDGE] |=> !state_reg.read_acknowledge)
    else $error("acknowledge not cleared");
  // Acknowledge stays until software drops it
  read_acknowledge_keep_a: assert property (@(posedge clk) disable iff (reset) // RULE_10
    state_reg.read_acknowledge && !(wr_stat && bus.wdata[frt_pkg::STAT_READ_ACKNOWLEDGE]) |=> state_reg.read_acknowledge)
    else $error("acknowledge dropped by itself");
  // A written request is taken when no acknowledge stands
  read_request_take_a: assert property (@(posedge clk) disable iff (reset) // RULE_09
    wr_ctrl && bus.wdata[frt_pkg::CTRL_READ_REQUEST] && !state_reg.read_acknowledge |=>
    state_reg.control[frt_pkg::CTRL_READ_REQUEST])
    else $error("read request not taken");
  // Request never outlives the acknowledge by more than a cycle
  read_request_drop_a: assert property (@(posedge clk) disable iff (reset) // RULE_09
    state_reg.read_acknowledge |=> !state_reg.control[frt_pkg::CTRL_READ_REQUEST])
    else $error("read request not dropped");
  // Clear bit never stays set
  clear_self_a: assert property (@(posedge clk) disable iff (reset) // RULE_11
    wr_ctrl && bus.wdata[frt_pkg::CTRL_CLEAR] |=> !state_reg.control[frt_pkg::CTRL_CLEAR])
    else $error("clear bit stuck");
  // Clear-on-match parks a zero count with the flag up
  match_park_a: assert property (@(posedge clk) disable iff (reset) // RULE_05
    match_clear_hit_s |=> parked_zero_s)
    else $error("match did not park a zero count");
  // Writing one clears the match flag when no match lands
  match_w1c_a: assert property (@(posedge clk) disable iff (reset) // RULE_16
    state_reg.match_flag && wr_stat && bus.wdata[frt_pkg::STAT_MATCH] &&
    !(running && tick && is_match) |=> !state_reg.match_flag)
    else $error("match flag not cleared");
  // Match flag rises only on a counted match
  match_origin_a: assert property (@(posedge clk) disable iff (reset) // RULE_16
    !state_reg.match_flag && !(running && tick && is_match) |=>
    !state_reg.match_flag)
    else $error("match flag set without match");
  // Overflow flag rises only on a counted wrap
  ovf_origin_a: assert property (@(posedge clk) disable iff (reset) // RULE_15
    !state_reg.ovf_flag && !(running && tick && (state_reg.count == 32'hffff_ffff)) |=>
    !state_reg.ovf_flag)
    else $error("overflow flag set without wrap");
  // Writes to the counter address leave the count alone
  count_ro_a: assert property (@(posedge clk) disable iff (reset) // RULE_14
    bus.wr && (bus.addr == frt_pkg::COUNT_OFS) && !(running && tick) |=>
    $stable(state_reg.count))
    else $error("counter written");
  // Period takes the written word whole
  period_load_a: assert property (@(posedge clk) disable iff (reset) // RULE_13
    bus.wr && (bus.addr == frt_pkg::PERIOD_OFS) |=> state_reg.period == $past(bus.wdata))
    else $error("period not loaded");
  // Period only changes on its own write
  period_keep_a: assert property (@(posedge clk) disable iff (reset) // RULE_13
    !(bus.wr && (bus.addr == frt_pkg::PERIOD_OFS)) |=> $stable(state_reg.period))
    else $error("period changed without write");
  // Low-speed source ticks on its filtered edges only
  src_lsi_a: assert property (@(posedge clk) disable iff (reset) // RULE_02 RULE_04
    state_reg.mode[frt_pkg::MODE_COUNT_CLOCK_SOURCE_LO +: 2] == frt_pkg::SRC_LSI |-> tick == lsi_rise)
    else $error("low-speed tick wrong");
  // Sub oscillator edges tick the counter undivided
  src_sub_a: assert property (@(posedge clk) disable iff (reset) // RULE_03
    state_reg.mode[frt_pkg::MODE_COUNT_CLOCK_SOURCE_LO +: 2] == frt_pkg::SRC_SUB |-> tick == sub_rise)
    else $error("sub oscillator tick wrong");
  // External source ticks only at the end of the prescale
  src_ext_a: assert property (@(posedge clk) disable iff (reset) // RULE_04
    state_reg.mode[frt_pkg::MODE_COUNT_CLOCK_SOURCE_LO +: 2] == frt_pkg::SRC_EXT_DIV && tick |->
    state_reg.ext_div == frt_pkg::EXT_DIV_MAX)
    else $error("external tick off prescale");
  // Reserved source never ticks
  src_resv_a: assert property (@(posedge clk) disable iff (reset) // RULE_04
    state_reg.mode[frt_pkg::MODE_COUNT_CLOCK_SOURCE_LO +: 2] == 2'h3 |-> !tick)
    else $error("reserved source ticked");
  // Line is low when no enabled flag stands
  irq_quiet_a: assert property (@(posedge clk) disable iff (reset) // RULE_18
    !(state_reg.match_flag && state_reg.mode[frt_pkg::MODE_MATCH_IE]) &&
    !(state_reg.ovf_flag && state_reg.mode[frt_pkg::MODE_OVF_IE]) |-> !irq)
    else $error("irq without enabled flag");
  // Mode write lands in the documented fields
  mode_load_a: assert property (@(posedge clk) disable iff (reset) // RULE_07 RULE_08
    bus.wr && (bus.addr == frt_pkg::MODE_OFS) |=> state_reg.mode[2:0] == $past(bus.wdata[2:0])
    && state_reg.mode[5:4] == $past(bus.wdata[5:4]))
    else $error("mode write lost");

endmodule

`default_nettype wire

// ===== src/frt_pkg.sv
package frt_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] MODE_OFS    = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] PERIOD_OFS  = 8'h08;
  localparam logic [7:0] COUNT_OFS   = 8'h0c;
  localparam logic [7:0] STATUS_OFS  = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

  // Mode register fields
  localparam int MODE_MATCH_IE   = 0;
  localparam int MODE_OVF_IE     = 1;
  localparam int MODE_MCD        = 2;
  localparam int MODE_COUNT_CLOCK_SOURCE_LO  = 4;

  // Control register fields
  localparam int CTRL_EN    = 0;
  localparam int CTRL_HOLD  = 1;
  localparam int CTRL_CLEAR = 2;
  localparam int CTRL_READ_REQUEST  = 3;

  // Status register fields
  localparam int STAT_MATCH = 0;
  localparam int STAT_OVF   = 1;
  localparam int STAT_READ_ACKNOWLEDGE  = 2;

  // Reset values
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [31:0] PERIOD_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET  = 32'h0000_0000;
  localparam logic [2:0]  MASK_RESET   = 3'h7;

  // Clock source selections
  localparam logic [1:0] SRC_LSI     = 2'h0;
  localparam logic [1:0] SRC_EXT_DIV = 2'h1;
  localparam logic [1:0] SRC_SUB     = 2'h2;

  // External oscillator prescale
  localparam int          EXT_DIV    = 32;
  localparam logic [4:0]  EXT_DIV_MAX = 5'(EXT_DIV - 1);

  // Bus request carrier
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } frt_bus_s;

endpackage

// ===== tb/frt_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none

module frt_timer_tb;
  logic              clk;          // 50 MHz bus clock
  logic              reset;        // Synchronous, active high
  frt_pkg::frt_bus_s bus;          // Register requests
  logic [31:0]       rdata;        // Read data, one cycle after the strobe
  logic              lsi_clk_pin;  // Low-speed oscillator stand-in
  logic              ext_osc_pin;  // External oscillator stand-in
  logic              sub_oscillator_pin;  // Sub oscillator stand-in
  logic              irq;          // Level interrupt
  int                miscompares;  // Mismatches seen
  int                checked;      // Comparisons made
  logic [31:0]       v;            // Scratch read value
  int                src;          // Clock source under test

  frt_timer uut (
    .clk         (clk),
    .reset       (reset),
    .bus         (bus),
    .rdata       (rdata),
    .lsi_clk_pin (lsi_clk_pin),
    .ext_osc_pin (ext_osc_pin),
    .sub_oscillator_pin (sub_oscillator_pin),
    .irq         (irq)
  );

  // Clock generator
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // One-cycle read strobe; data stands only in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Compare and report
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Pulse all oscillator pins; slow pulses so the synchronizers see each one
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      {lsi_clk_pin, ext_osc_pin, sub_oscillator_pin} <= 3'h7;
      repeat (4) @(posedge clk);
      {lsi_clk_pin, ext_osc_pin, sub_oscillator_pin} <= 3'h0;
      repeat (3) @(posedge clk);
    end
    // Last edge needs a few cycles through the synchronizer
    repeat (8) @(posedge clk);
  endtask

  // Snapshot the count through request and acknowledge
  task automatic snap(input logic [7:0] ctl, output logic [31:0] val);
    int          i;
    logic [31:0] s;
    s = 32'h0;
    wr(frt_pkg::STATUS_OFS, 32'h4);  // A new request needs the old ack dropped
    wr(frt_pkg::CONTROL_OFS, {24'h0, ctl | 8'h08});
    for (i = 0; i < 20 && s[2] !== 1'b1; i++) rd(frt_pkg::STATUS_OFS, s);
    chk("read_ack", 32'h1, {31'h0, s[2]});
    rd(frt_pkg::COUNT_OFS, val);
  endtask

  // Verdict and end of run
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    summarize;
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    bus = '0;
    {lsi_clk_pin, ext_osc_pin, sub_oscillator_pin} = 3'h0;
    miscompares = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    // Reset values, mask register and an unmapped hole
    rd(frt_pkg::MODE_OFS, v);     chk("mode", 32'h0, v);
    rd(frt_pkg::CONTROL_OFS, v);  chk("control", 32'h0, v);
    rd(frt_pkg::PERIOD_OFS, v);   chk("period", 32'h0, v);
    rd(frt_pkg::COUNT_OFS, v);    chk("count", 32'h0, v);
    rd(frt_pkg::STATUS_OFS, v);   chk("status", 32'h0, v);
    rd(frt_pkg::IRQ_MASK_OFS, v); chk("mask", 32'h7, v);
    rd(8'h18, v);                 chk("unmapped", 32'h0, v);
    wr(frt_pkg::PERIOD_OFS, 32'ha5a5_5a5a);
    rd(frt_pkg::PERIOD_OFS, v);   chk("period", 32'ha5a5_5a5a, v);
    // Every clock source, 64 pin edges each; divide by 32 gives 2, reserved gives 0
    for (src = 0; src < 4; src++) begin
      wr(frt_pkg::MODE_OFS, {26'h0, src[1:0], 4'h0});
      wr(frt_pkg::CONTROL_OFS, 32'h5);
      tick(64);
      wr(frt_pkg::COUNT_OFS, 32'hffff_ffff);
      snap(8'h01, v);
      chk("count_src", (src == 1) ? 32'd2 : (src == 3) ? 32'd0 : 32'd64, v);
    end
    // Hold, disable and clear on the sub oscillator, clear-on-match off
    wr(frt_pkg::MODE_OFS, 32'h24);
    wr(frt_pkg::CONTROL_OFS, 32'h5);
    tick(5);
    snap(8'h03, v); chk("count_run", 32'd5, v);
    tick(3);
    snap(8'h03, v); chk("count_hold", 32'd5, v);
    snap(8'h00, v);
    tick(3);
    snap(8'h00, v); chk("count_off", 32'd5, v);
    snap(8'h01, v);
    tick(2);
    snap(8'h01, v); chk("count_resume", 32'd7, v);
    wr(frt_pkg::CONTROL_OFS, 32'h5);
    snap(8'h01, v); chk("count_clear", 32'd0, v);
    // Match without clearing keeps counting past the period
    wr(frt_pkg::PERIOD_OFS, 32'h3);
    wr(frt_pkg::MODE_OFS, 32'h25);
    wr(frt_pkg::CONTROL_OFS, 32'h5);
    tick(5);
    snap(8'h01, v); chk("count_pass", 32'd5, v);
    rd(frt_pkg::STATUS_OFS, v); chk("match_flag", 32'h1, {31'h0, v[0]});
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(frt_pkg::MODE_OFS, 32'h24);
    rd(frt_pkg::STATUS_OFS, v); chk("irq_mie_off", 32'h0, {31'h0, irq});
    wr(frt_pkg::MODE_OFS, 32'h25);
    wr(frt_pkg::IRQ_MASK_OFS, 32'h0);
    rd(frt_pkg::STATUS_OFS, v); chk("irq_masked", 32'h0, {31'h0, irq});
    wr(frt_pkg::IRQ_MASK_OFS, 32'h7);
    wr(frt_pkg::STATUS_OFS, 32'h1);
    rd(frt_pkg::STATUS_OFS, v); chk("status_w1c", 32'h4, v);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    // Clear-on-match: zero after the match and parked until the flag goes
    wr(frt_pkg::MODE_OFS, 32'h21);
    wr(frt_pkg::CONTROL_OFS, 32'h5);
    tick(5);
    snap(8'h01, v); chk("count_parked", 32'd0, v);
    rd(frt_pkg::STATUS_OFS, v); chk("match_flag", 32'h1, {31'h0, v[0]});
    tick(2);
    snap(8'h01, v); chk("count_still", 32'd0, v);
    wr(frt_pkg::STATUS_OFS, 32'h1);
    tick(2);
    snap(8'h01, v); chk("count_restart", 32'd2, v);
    // Acknowledge clear written in the cycle the request is captured: the capture wins
    wr(frt_pkg::STATUS_OFS, 32'h4);
    @(posedge clk);
    bus <= '{addr: frt_pkg::CONTROL_OFS, wdata: 32'h9, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: frt_pkg::STATUS_OFS, wdata: 32'h4, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    rd(frt_pkg::STATUS_OFS, v); chk("read_acknowledge_race", 32'h1, {31'h0, v[2]});
    rd(frt_pkg::COUNT_OFS, v);  chk("count_race", 32'd2, v);
    summarize;
  end
endmodule

`default_nettype wire
